// ### hdl/ptpe_tx_edit.sv
`timescale 1ns/1ps
module ptpe_tx_edit #(
  parameter int TBL_DEPTH = 128
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Client stream in
  input wire logic in_valid,
  output logic in_ready,
  input wire ptpe_pkg::ptpe_beat_s in_beat,
  input wire ptpe_pkg::ptpe_cmd_s in_cmd,
  // Delay table load
  input wire logic tbl_wr,
  input wire logic [ptpe_pkg::PTPE_IDX_W-1:0] tbl_addr,
  input wire logic [ptpe_pkg::PTPE_CF_W-1:0] tbl_data,
  // Edited stream out
  output logic out_valid,
  input wire logic out_ready,
  output ptpe_pkg::ptpe_beat_s out_beat,
  // Segmented command sideband
  input wire logic seg_valid,
  input wire logic [ptpe_pkg::PTPE_SEGS*ptpe_pkg::PTPE_SEG_INF_W-1:0] seg_inframe,
  input wire ptpe_pkg::ptpe_seg_cmd_s [ptpe_pkg::PTPE_SEGS-1:0] seg_cmd_in,
  output logic [ptpe_pkg::PTPE_SEGS-1:0] seg_cmd_stb,
  output ptpe_pkg::ptpe_seg_cmd_s [ptpe_pkg::PTPE_SEGS-1:0] seg_cmd_out
);

  localparam int INF_W = ptpe_pkg::PTPE_SEGS * ptpe_pkg::PTPE_SEG_INF_W;
  localparam int WIN_BYTES = 2 * ptpe_pkg::PTPE_BEAT_BYTES;
  localparam int BEAT_W = $bits(ptpe_pkg::ptpe_beat_s);

  if (TBL_DEPTH < 1 || TBL_DEPTH > 2 ** ptpe_pkg::PTPE_IDX_W) begin : g_chk
    $error("ptpe_tx_edit: TBL_DEPTH out of range for the index width");
  end

  typedef struct packed {
    logic [TBL_DEPTH-1:0][ptpe_pkg::PTPE_CF_W-1:0] tbl;
    ptpe_pkg::ptpe_beat_s pend;
    logic pend_v;
    ptpe_pkg::ptpe_cmd_s cmd;
    logic [ptpe_pkg::PTPE_POS_W-1:0] cnt;
    logic [15:0] dsum;
    logic seg_prev;
    logic [ptpe_pkg::PTPE_SEGS-1:0] seg_stb;
    ptpe_pkg::ptpe_seg_cmd_s [ptpe_pkg::PTPE_SEGS-1:0] seg_cmd;
  } ptpe_state_s;

  function automatic logic [15:0] ptpe_oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : ptpe_oc_add

  ptpe_state_s st_r;
  ptpe_state_s st_nxt;
  ptpe_pkg::ptpe_cmd_s cur;
  ptpe_pkg::ptpe_beat_s stg_beat;
  logic [0:WIN_BYTES-1][7:0] win;
  logic [ptpe_pkg::PTPE_CF_W-1:0] dly;
  logic [ptpe_pkg::PTPE_CF_W-1:0] old_cf;
  logic [ptpe_pkg::PTPE_CF_W-1:0] new_cf;
  logic [16:0] base;
  logic [16:0] cf_end;
  logic [16:0] cs_at;
  logic [16:0] pos;
  logic [3:0] shift;
  logic [3:0] ext_at;
  logic [15:0] d_now;
  logic [15:0] d_cur;
  logic [15:0] ext_old;
  logic [15:0] ext_new;
  logic [INF_W-1:0] seg_start;
  logic in_fire;
  logic cf_hit;
  logic stg_v;
  logic buf_rdy;
  logic [BEAT_W-1:0] buf_out;

  // A held beat other than an end beat waits for its successor, so edits that straddle beats can patch it
  assign in_ready = !st_r.pend_v || buf_rdy;
  assign stg_v = st_r.pend_v && (st_r.pend.eop || in_valid);
  assign out_beat = ptpe_pkg::ptpe_beat_s'(buf_out);
  assign seg_cmd_stb = st_r.seg_stb;
  assign seg_cmd_out = st_r.seg_cmd;

  always_comb begin
    st_nxt = st_r;
    in_fire = in_valid && in_ready;
    cur = in_beat.sop ? in_cmd : st_r.cmd;
    base = in_beat.sop ? 17'h00000 : {1'b0, st_r.cnt};
    win = {st_r.pend.data, in_beat.data};
    dly = ptpe_pkg::PTPE_CF_W'(0);
    if (32'(cur.delay_table_index) < TBL_DEPTH) begin
      dly = st_r.tbl[cur.delay_table_index];
    end
    // Correction field patched once its last byte is in the incoming beat
    cf_end = {1'b0, cur.cf_pos} + 17'(ptpe_pkg::PTPE_CF_BYTES - 1);
    cf_hit = in_fire && cur.add_path_delay_req && (cf_end >= base) &&
             (cf_end <= base + 17'(ptpe_pkg::PTPE_BEAT_BYTES - 1));
    shift = 4'(cf_end + 17'h00001 - base);
    old_cf = '0;
    for (int b = 0; b < ptpe_pkg::PTPE_CF_BYTES; b++) begin
      old_cf[63-8*b -: 8] = win[4'(int'(shift) + b)];
    end
    new_cf = old_cf + dly;
    d_now = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      d_now = ptpe_oc_add(d_now, old_cf[16*i +: 16]);
      d_now = ptpe_oc_add(d_now, ~new_cf[16*i +: 16]);
    end
    if (cf_hit) begin
      for (int b = 0; b < ptpe_pkg::PTPE_CF_BYTES; b++) begin
        win[4'(int'(shift) + b)] = new_cf[63-8*b -: 8];
      end
    end
    // Checksum bytes addressed by the client position, offset into the window
    cs_at = {1'b0, cur.csum_pos} + 17'(ptpe_pkg::PTPE_BEAT_BYTES);
    pos = base;
    for (int w = 0; w < WIN_BYTES; w++) begin
      pos = base + 17'(w);
      if (cur.zero_csum_req && pos >= cs_at && pos < cs_at + 17'(ptpe_pkg::PTPE_CSUM_BYTES)) begin
        win[w] = 8'h00;
      end
    end
    // Extension field is the tail of the client frame, just ahead of the CRC
    d_cur = cf_hit ? d_now : st_r.dsum;
    ext_at = 4'(WIN_BYTES - ptpe_pkg::PTPE_EXT_BACK) - {1'b0, in_beat.empty};
    ext_old = {win[ext_at], win[ext_at + 4'h1]};
    ext_new = ptpe_oc_add(ext_old, d_cur);
    if (in_fire && in_beat.eop && cur.ext_bytes_fixup_req) begin
      win[ext_at] = ext_new[15:8];
      win[ext_at + 4'h1] = ext_new[7:0];
    end
    stg_beat = st_r.pend;
    if (in_fire) begin
      stg_beat.data = win[0:7];
    end
    if (in_fire) begin
      st_nxt.pend_v = 1'b1;
      st_nxt.pend.data = win[8:15];
      st_nxt.pend.sop = in_beat.sop;
      st_nxt.pend.eop = in_beat.eop;
      st_nxt.pend.empty = in_beat.empty;
      st_nxt.cnt = in_beat.eop ? ptpe_pkg::PTPE_CNT_RST :
                   ptpe_pkg::PTPE_POS_W'(base + 17'(ptpe_pkg::PTPE_BEAT_BYTES));
      st_nxt.dsum = cf_hit ? d_now : (in_beat.sop ? ptpe_pkg::PTPE_DSUM_RST : st_r.dsum);
      if (in_beat.sop) begin
        st_nxt.cmd = in_cmd;
      end
    end else if (stg_v && buf_rdy) begin
      st_nxt.pend_v = 1'b0;
    end
    if (tbl_wr && 32'(tbl_addr) < TBL_DEPTH) begin
      st_nxt.tbl[tbl_addr] = tbl_data;
    end
    // Segment start: an inframe bit rising against its predecessor
    seg_start = seg_inframe & ~{seg_inframe[INF_W-2:0], st_r.seg_prev};
    st_nxt.seg_stb = '0;
    if (seg_valid) begin
      st_nxt.seg_prev = seg_inframe[INF_W-1];
      for (int k = 0; k < ptpe_pkg::PTPE_SEGS; k++) begin
        if (|seg_start[k*ptpe_pkg::PTPE_SEG_INF_W +: ptpe_pkg::PTPE_SEG_INF_W]) begin
          st_nxt.seg_stb[k] = 1'b1;
          st_nxt.seg_cmd[k] = seg_cmd_in[k];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Two entries absorb a receiver stall without dropping the staged word
  ptpe_skid_buf #(
    .W(BEAT_W)
  ) u_buf (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(stg_v),
    .in_ready(buf_rdy),
    .in_data(stg_beat),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(buf_out)
  );

  a_sop_cmd_capture: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_fire && in_beat.sop) |=> (st_r.cmd == $past(in_cmd)))
    else $error("command not captured on start beat");

  a_mid_cmd_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_fire && !in_beat.sop) |=> (st_r.cmd == $past(st_r.cmd)))
    else $error("command changed on a middle beat");

  a_plain_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_fire && in_beat.sop && !in_cmd.zero_csum_req && !in_cmd.ext_bytes_fixup_req &&
     !in_cmd.add_path_delay_req) |=> (st_r.pend.data == $past(in_beat.data)))
    else $error("unedited beat was altered");

  a_csum_zeroed: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_fire && in_beat.sop && in_cmd.zero_csum_req && in_cmd.csum_pos == 16'h0002)
    |=> (st_r.pend.data[47:32] == 16'h0000))
    else $error("checksum bytes not zeroed");

  a_delay_added: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_fire && in_beat.sop && !in_beat.eop && in_cmd.add_path_delay_req && in_cmd.cf_pos == 16'h0000 &&
     !in_cmd.zero_csum_req) |=> (st_r.pend.data == $past(in_beat.data) + $past(dly)))
    else $error("path delay not added to correction field");

  a_ext_rewrite: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (in_fire && in_beat.eop && !in_beat.sop && in_beat.empty == 3'h0 && cur.ext_bytes_fixup_req &&
     !cf_hit && !cur.zero_csum_req)
    |=> (st_r.pend.data[15:0] == ptpe_oc_add($past(in_beat.data[15:0]), $past(st_r.dsum))))
    else $error("extension bytes not rewritten");

  a_seg_lo_sample: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (seg_valid && (seg_inframe[7:0] & ~{seg_inframe[6:0], st_r.seg_prev}) != 8'h00)
    |=> (seg_cmd_stb[0] && seg_cmd_out[0] == $past(seg_cmd_in[0])))
    else $error("low segment command not sampled");

  a_seg_hi_sample: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(seg_valid && (seg_inframe[15:8] & ~seg_inframe[14:7]) != 8'h00) |=> !seg_cmd_stb[1])
    else $error("high segment command sampled without start");

endmodule : ptpe_tx_edit

// ### include/ptpe_pkg.sv
package ptpe_pkg;

  // Client beat geometry
  localparam int PTPE_BEAT_BYTES = 8;
  localparam int PTPE_DATA_W = 64;
  localparam int PTPE_EMPTY_W = 3;
  localparam int PTPE_POS_W = 16;

  // Field sizes and placement
  localparam int PTPE_CF_BYTES = 8;
  localparam int PTPE_CF_W = 64;
  localparam int PTPE_CSUM_BYTES = 2;
  localparam int PTPE_EXT_BYTES = 2;
  localparam int PTPE_EXT_BACK = 2;

  // Delay lookup index and segmented sideband
  localparam int PTPE_IDX_W = 7;
  localparam int PTPE_SEGS = 2;
  localparam int PTPE_SEG_INF_W = 8;

  // Reset values
  localparam logic [PTPE_POS_W-1:0] PTPE_CNT_RST = 16'h0000;
  localparam logic [15:0] PTPE_DSUM_RST = 16'h0000;

  typedef struct packed {
    logic [PTPE_DATA_W-1:0] data;
    logic sop;
    logic eop;
    logic [PTPE_EMPTY_W-1:0] empty;
  } ptpe_beat_s;

  typedef struct packed {
    logic zero_csum_req;
    logic ext_bytes_fixup_req;
    logic add_path_delay_req;
    logic [PTPE_IDX_W-1:0] delay_table_index;
    logic [PTPE_POS_W-1:0] csum_pos;
    logic [PTPE_POS_W-1:0] cf_pos;
  } ptpe_cmd_s;

  typedef struct packed {
    logic zero_csum_req;
    logic ext_bytes_fixup_req;
    logic add_path_delay_req;
    logic [PTPE_IDX_W-1:0] delay_table_index;
  } ptpe_seg_cmd_s;

endpackage : ptpe_pkg

// ### hdl/ptpe_skid_buf.sv
`timescale 1ns/1ps
module ptpe_skid_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  if (W < 1) begin : g_chk
    $error("ptpe_skid_buf: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0] cnt;
  } ptpe_buf_state_s;

  ptpe_buf_state_s st_r;
  ptpe_buf_state_s st_nxt;
  logic push;
  logic pop;

  // Ready depends on occupancy only, so no path from out_ready to in_ready
  assign in_ready = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data = st_r.e0;

  always_comb begin
    st_nxt = st_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (pop) begin
      st_nxt.e0 = st_r.e1;
    end
    case ({push, pop})
      2'b10: begin
        if (st_r.cnt == 2'h0) begin
          st_nxt.e0 = in_data;
        end else begin
          st_nxt.e1 = in_data;
        end
        st_nxt.cnt = st_r.cnt + 2'h1;
      end
      2'b01: st_nxt.cnt = st_r.cnt - 2'h1;
      2'b11: begin
        if (st_r.cnt == 2'h1) begin
          st_nxt.e0 = in_data;
        end else begin
          st_nxt.e1 = in_data;
        end
      end
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_buf_hold_word: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("buffer dropped or changed a stalled word");

  a_buf_full_stall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (push && !pop && st_r.cnt == 2'h1) |=> !in_ready)
    else $error("buffer full but still ready");

endmodule : ptpe_skid_buf

// ### sim/ptpe_sink.sv
`timescale 1ns/1ps
module ptpe_sink (
  // Clock
  input wire logic sys_clk,
  // Stall control
  input wire logic stall_en,
  // Receiver handshake
  output logic out_ready
);
  logic [15:0] stall_r = 16'hace1;
  // Irregular stalls so the two-entry buffer fills and refuses
  always @(negedge sys_clk) begin
    stall_r <= {stall_r[14:0], stall_r[15] ^ stall_r[13] ^ stall_r[12] ^ stall_r[10]};
    out_ready <= !stall_en | stall_r[0];
  end
endmodule : ptpe_sink

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic in_valid = 1'b0;
  logic tbl_wr = 1'b0;
  logic seg_valid = 1'b0;
  logic stall_en = 1'b0;
  logic in_ready, out_valid, out_ready;
  ptpe_pkg::ptpe_beat_s in_beat = '0;
  ptpe_pkg::ptpe_beat_s out_beat;
  ptpe_pkg::ptpe_cmd_s in_cmd = '0;
  logic [6:0] tbl_addr = 7'h00;
  logic [63:0] tbl_data = 64'h0;
  logic [15:0] seg_inframe = 16'h0000;
  ptpe_pkg::ptpe_seg_cmd_s [1:0] seg_cmd_in = '0;
  ptpe_pkg::ptpe_seg_cmd_s [1:0] seg_cmd_out;
  logic [1:0] seg_cmd_stb;
  logic [31:0] lfsr = 32'hc6c0fdd9;
  logic [63:0] d_lo, d_hi;
  logic [7:0] fb [0:31];
  logic [7:0] ef [0:31];
  int err_count = 0;
  int checks = 0;
  ptpe_pkg::ptpe_beat_s exp_q[$];

  always #2.5 sys_clk = ~sys_clk;

  ptpe_tx_edit ptpe_tx_edit_i (.sys_clk(sys_clk), .reset_n(reset_n), .in_valid(in_valid), .in_ready(in_ready),
    .in_beat(in_beat), .in_cmd(in_cmd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat), .seg_valid(seg_valid),
    .seg_inframe(seg_inframe), .seg_cmd_in(seg_cmd_in), .seg_cmd_stb(seg_cmd_stb), .seg_cmd_out(seg_cmd_out));
  ptpe_sink ptpe_sink_i (.sys_clk(sys_clk), .stall_en(stall_en), .out_ready(out_ready));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = a + b;
    return s[15:0] + {15'h0, s[16]};
  endfunction : oc

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Scoreboard side: oldest expected beat against each accepted output beat
  always @(posedge sys_clk) begin
    if (reset_n && out_valid && out_ready) begin
      if (exp_q.size() == 0) check("spare beat", 1, 0);
      else check("out_beat", out_beat, exp_q.pop_front());
    end
  end

  task automatic tbl_write(input logic [6:0] a, input logic [63:0] d);
    @(negedge sys_clk);
    tbl_wr = 1'b1;
    tbl_addr = a;
    tbl_data = d;
    @(negedge sys_clk);
    tbl_wr = 1'b0;
  endtask : tbl_write

  function automatic void add_cf(input int p, input int q, input logic [63:0] d);
    logic [63:0] cf;
    logic [15:0] so, sn, e;
    for (int k = 0; k < 8; k++) cf[63-8*k -: 8] = ef[p+k];
    so = oc(oc(cf[63:48], cf[47:32]), oc(cf[31:16], cf[15:0]));
    cf = cf + d;
    sn = oc(oc(cf[63:48], cf[47:32]), oc(cf[31:16], cf[15:0]));
    for (int k = 0; k < 8; k++) ef[p+k] = cf[63-8*k -: 8];
    e = oc(oc({ef[q], ef[q+1]}, so), ~sn);
    if (in_cmd.ext_bytes_fixup_req) {ef[q], ef[q+1]} = e;
  endfunction : add_cf

  // Four-beat frame; kind picks the command set
  task automatic run_pkt(input int kind);
    ptpe_pkg::ptpe_cmd_s cmd;
    ptpe_pkg::ptpe_beat_s b;
    int n;
    cmd = '0;
    for (int k = 0; k < 32; k++) fb[k] = 8'(rnd());
    ef = fb;
    case (kind)
      0: begin
        cmd.zero_csum_req = 1'b1;
        cmd.csum_pos = 16'h0007;
        ef[7] = 8'h00;
        ef[8] = 8'h00;
      end
      1: begin
        cmd.add_path_delay_req = 1'b1;
        cmd.delay_table_index = 7'h05;
        cmd.cf_pos = 16'h0003;
      end
      2: begin
        cmd.add_path_delay_req = 1'b1;
        cmd.ext_bytes_fixup_req = 1'b1;
        cmd.delay_table_index = 7'h7f;
        cmd.cf_pos = 16'h000d;
      end
      4: begin
        cmd.add_path_delay_req = 1'b1;
        cmd.ext_bytes_fixup_req = 1'b1;
        cmd.delay_table_index = 7'h05;
        cmd.cf_pos = 16'h0000;
      end
      5: begin
        cmd.zero_csum_req = 1'b1;
        cmd.csum_pos = 16'h0002;
        ef[2] = 8'h00;
        ef[3] = 8'h00;
      end
      default: ;
    endcase
    in_cmd = cmd;
    if (kind == 1) add_cf(3, 30, d_lo);
    if (kind == 2) add_cf(13, 30, d_hi);
    // Short last beat: three unused tail bytes move the extension field
    if (kind == 4) add_cf(0, 27, d_lo);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 8; k++) b.data[63-8*k -: 8] = ef[8*i+k];
      b.sop = (i == 0);
      b.eop = (i == 3);
      b.empty = (i == 3 && kind == 4) ? 3'h3 : 3'h0;
      exp_q.push_back(b);
    end
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      in_valid = 1'b1;
      for (int k = 0; k < 8; k++) in_beat.data[63-8*k -: 8] = fb[8*i+k];
      in_beat.sop = (i == 0);
      in_beat.eop = (i == 3);
      in_beat.empty = (i == 3 && kind == 4) ? 3'h3 : 3'h0;
      // Off the start beat the command lines carry noise
      in_cmd = (i == 0) ? cmd : ptpe_pkg::ptpe_cmd_s'(42'({rnd(), rnd()}));
      n = 0;
      while (!in_ready && n < 100) begin
        @(negedge sys_clk);
        n++;
      end
      if (n == 100) begin
        check("in_ready wait", 0, 1);
        final_report();
      end
    end
    @(negedge sys_clk);
    in_valid = 1'b0;
  endtask : run_pkt

  logic [15:0] seg_inf [0:6] = '{16'h00ff, 16'hff00, 16'hffff, 16'h0f0f, 16'h00ff, 16'h0001, 16'h8181};
  logic seg_v [0:6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [1:0] seg_exp [0:6] = '{2'b01, 2'b10, 2'b00, 2'b10, 2'b00, 2'b01, 2'b11};

  initial begin
    ptpe_pkg::ptpe_seg_cmd_s [1:0] sc;
    int n;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check("in_ready rst", in_ready, 1);
    check("out_valid rst", out_valid, 0);
    check("seg_cmd_stb rst", seg_cmd_stb, 0);
    reset_n = 1'b1;
    d_lo = {rnd(), rnd()};
    d_hi = {rnd(), rnd()};
    tbl_write(7'h05, d_lo);
    tbl_write(7'h7f, d_hi);
    // Back to back, first free-running then against stalls
    for (int r = 0; r < 2; r++) begin
      stall_en = (r == 1);
      for (int kind = 0; kind < 6; kind++) run_pkt(kind);
    end
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    check("drain left", exp_q.size(), 0);
    for (int s = 0; s < 7; s++) begin
      @(negedge sys_clk);
      sc = 20'(rnd());
      seg_cmd_in = sc;
      seg_valid = seg_v[s];
      seg_inframe = seg_inf[s];
      @(negedge sys_clk);
      seg_valid = 1'b0;
      check("seg_cmd_stb", seg_cmd_stb, seg_exp[s]);
      for (int k = 0; k < 2; k++)
        if (seg_exp[s][k]) check("seg_cmd_out", seg_cmd_out[k], sc[k]);
    end
    final_report();
  end
endmodule : tb
